// ===== include/mes_defines.svh
// Register offsets, field positions, reset values and timing counts of the error supervisor
`ifndef MES_DEFINES_SVH
`define MES_DEFINES_SVH

// Register byte offsets
`define MES_OFF_CFG 8'h00
`define MES_OFF_TMO 8'h04
`define MES_OFF_VLOW 8'h08
`define MES_OFF_VHIGH 8'h0c
`define MES_OFF_TMAX 8'h10
`define MES_OFF_STAT 8'h14
`define MES_OFF_SKIND 8'h18
`define MES_OFF_CMD 8'h1c
`define MES_OFF_CNT 8'h40

// Error flag, status stop and command bit positions
`define MES_E_SS 0
`define MES_E_REQ 1
`define MES_E_TMO 2
`define MES_E_LIM 3
`define MES_E_VLOW 4
`define MES_E_VHIGH 5
`define MES_E_DRV 6
`define MES_E_TEMP 7
`define MES_E_EXT 8
`define MES_E_SER 9
`define MES_STAT_STOP 10
`define MES_CMD_CLRCNT 0

// Reset values
`define MES_CFG_RST 11'h000
`define MES_TMO_RST 16'h0000
`define MES_VLOW_RST 16'h157c
`define MES_VHIGH_RST 16'h7530
`define MES_TMAX_RST 12'h0a0a

// Scaled input thresholds: 8 % and 50 % of full scale 3200
`define MES_NEUTRAL_SUM 14'h0100
`define MES_SWITCH_ON 13'h0640

// Timing
`define MES_CLK_NS 50
`define MES_MS_NS 1000000
`define MES_MS_CYC ((`MES_MS_NS + `MES_CLK_NS - 1) / `MES_CLK_NS)
`define MES_BLINK_MS 10'h1f4
`define MES_FLICK_MS 8'h1e

`endif

// ===== include/mes_pkg.sv
// Types shared by the error supervisor and its surroundings
package mes_pkg;

	typedef enum logic [1:0] {
		MES_MODE_SERIAL = 2'b00,
		MES_MODE_ANALOG = 2'b01,
		MES_MODE_RC = 2'b10
	} mes_mode_t;

	typedef enum logic [1:0] {
		MES_ROLE_NONE = 2'b00,
		MES_ROLE_KILL = 2'b01,
		MES_ROLE_FWD = 2'b10,
		MES_ROLE_REV = 2'b11
	} mes_role_t;

	// Configuration word, low bits of the configuration register
	typedef struct packed {
		logic [1:0] spd_en;
		mes_role_t role1;
		mes_role_t role0;
		logic crc_en;
		logic extl_dis;
		mes_mode_t mode;
		logic ss_dis;
	} mes_cfg_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} mes_bus_req_t;

	typedef struct packed {
		logic crc;
		logic format;
		logic overrun;
		logic noise;
		logic frame;
	} mes_ser_ev_t;

	typedef struct packed {
		logic ser_valid;
		logic ser_resume;
		logic usb_set_speed;
		logic usb_exit_ss;
		logic usb_drv_ok;
		logic usb_xfer;
	} mes_host_cmd_t;

	typedef struct packed {
		logic [1:0] valid;
		logic [1:0][12:0] scaled;
	} mes_chan_t;

endpackage : mes_pkg

// ===== hdl/mes_supervisor.sv
// Motor error supervisor: fault gathering, motor stop, error line, counters and USB indicator
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "mes_defines.svh"

module mes_supervisor #(
	parameter int MS_CYCLES = `MES_MS_CYC,
	parameter int CNT_W = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire mes_pkg::mes_bus_req_t bus,
	output logic [31:0] rdata,
	input wire mes_pkg::mes_host_cmd_t cmd,
	input wire mes_pkg::mes_ser_ev_t ser_ev,
	input wire mes_pkg::mes_chan_t chan,
	input wire logic [12:0] req_speed,
	input wire logic [15:0] vin_mv,
	input wire logic [11:0] temp_raw,
	input wire logic drv_fault_n,
	input wire logic usb_present,
	input wire logic err_line_i,
	output logic err_line_o,
	output logic err_line_oe_n,
	output logic [9:0] err_flags,
	output logic motor_stop,
	output logic [12:0] motor_speed,
	output logic usb_led
);
	import mes_pkg::*;

	localparam int NCNT = 15;

	typedef struct packed {
		mes_cfg_t cfg;
		logic [15:0] tmo;
		logic [15:0] vlow;
		logic [15:0] vhigh;
		logic [11:0] tmax;
		logic [9:0] err;
		logic stop;
		logic [4:0] skind;
		logic [NCNT-1:0][CNT_W-1:0] cnt;
		logic [15:0] ms_div;
		logic [15:0] idle_ms;
		logic [9:0] led_ms;
		logic blink;
		logic usb_ok;
		logic [7:0] flick_ms;
		logic led;
		logic [12:0] speed;
		logic [31:0] rdata;
		logic [1:0] drv_s;
		logic [1:0] extl_s;
		logic [1:0] usb_s;
		logic [1:0] own_d;
	} mes_state_t;

	mes_state_t st_reg;
	mes_state_t st_next;

	// Reset image of the whole state
	localparam mes_state_t ST_RST = '{
		cfg: mes_cfg_t'(`MES_CFG_RST),
		tmo: `MES_TMO_RST,
		vlow: `MES_VLOW_RST,
		vhigh: `MES_VHIGH_RST,
		tmax: `MES_TMAX_RST,
		drv_s: 2'h3,
		default: '0
	};

	logic serial_mode;
	logic ms_tick;
	logic cmd_any;
	logic resume;
	logic [4:0] ser_kinds;
	logic [1:0][12:0] ch_abs;
	logic [1:0] ch_on;
	logic [1:0] ch_bad;
	logic [1:0] ch_kill;
	logic [1:0] ch_fwd;
	logic [1:0] ch_rev;
	logic [13:0] spd_sum;
	logic neutral;
	logic other_stop;
	logic own_err;
	logic speed_pos;
	logic speed_neg;
	logic [9:0] flags_nx;
	logic [NCNT-1:0] cnt_ev;
	logic cnt_clr;
	logic [NCNT-1:0][CNT_W-1:0] cnt_nx;
	logic [3:0] cnt_idx;

	assign serial_mode = (st_reg.cfg.mode == MES_MODE_SERIAL);
	assign ms_tick = (st_reg.ms_div == 16'(MS_CYCLES - 1));

	// Commands that prove the host is alive; a resume is itself a valid serial command
	assign cmd_any = cmd.ser_valid | cmd.ser_resume | cmd.usb_set_speed | cmd.usb_exit_ss;
	assign resume = cmd.ser_resume | cmd.usb_exit_ss;

	// CRC errors only count while checking is enabled
	assign ser_kinds = {ser_ev.crc & st_reg.cfg.crc_en, ser_ev.format, ser_ev.overrun,
		ser_ev.noise, ser_ev.frame};

	// Per-channel validity, switch and neutrality terms
	generate
		for (genvar g = 0; g < 2; g++) begin : g_chan
			mes_role_t role;
			logic spd;
			assign role = (g == 0) ? st_reg.cfg.role0 : st_reg.cfg.role1;
			// Speed channels only matter outside serial mode
			assign spd = st_reg.cfg.spd_en[g] & ~serial_mode;
			assign ch_abs[g] = chan.scaled[g][12] ? 13'(-chan.scaled[g]) : chan.scaled[g];
			assign ch_on[g] = ~chan.scaled[g][12] && (chan.scaled[g] > `MES_SWITCH_ON);
			assign ch_bad[g] = ~chan.valid[g] & (spd | (role != MES_ROLE_NONE));
			assign ch_kill[g] = ch_on[g] & (role == MES_ROLE_KILL);
			assign ch_fwd[g] = ch_on[g] & (role == MES_ROLE_FWD);
			assign ch_rev[g] = ch_on[g] & (role == MES_ROLE_REV);
		end
	endgenerate

	// Sum of the absolute speed inputs against the 8 % neutral band
	assign spd_sum = (st_reg.cfg.spd_en[0] ? {1'b0, ch_abs[0]} : 14'h0000)
		+ (st_reg.cfg.spd_en[1] ? {1'b0, ch_abs[1]} : 14'h0000);
	assign neutral = (spd_sum < `MES_NEUTRAL_SUM);

	assign speed_pos = ~req_speed[12] && (req_speed != 13'h0000);
	assign speed_neg = req_speed[12];

	// Errors other than safe start, as seen last cycle
	assign other_stop = |st_reg.err[`MES_E_SER:`MES_E_REQ];
	// Own errors exclude the sensed line so the line cannot hold itself up
	assign own_err = |{st_reg.err[`MES_E_SER], st_reg.err[`MES_E_TEMP:`MES_E_SS]};

	// Safe start
	always_comb begin
		flags_nx[`MES_E_SS] = 1'b0;
		if (!st_reg.cfg.ss_dis) begin
			if (serial_mode) begin
				// Held until a resume arrives with nothing else wrong
				flags_nx[`MES_E_SS] = other_stop | (st_reg.err[`MES_E_SS] & ~resume);
			end else begin
				flags_nx[`MES_E_SS] = (other_stop | st_reg.err[`MES_E_SS]) & ~neutral;
			end
		end
	end

	// Remaining error conditions, evaluated every cycle
	assign flags_nx[`MES_E_REQ] = |ch_bad;
	assign flags_nx[`MES_E_TMO] = serial_mode && (st_reg.tmo != 16'h0000)
		&& (st_reg.idle_ms >= st_reg.tmo);
	assign flags_nx[`MES_E_LIM] = (|ch_kill) | ((|ch_fwd) & speed_pos)
		| ((|ch_rev) & speed_neg);
	// A supply of zero falls under the low threshold as well
	assign flags_nx[`MES_E_VLOW] = (vin_mv < st_reg.vlow) || (vin_mv == 16'h0000);
	assign flags_nx[`MES_E_VHIGH] = (vin_mv > st_reg.vhigh);
	assign flags_nx[`MES_E_DRV] = ~st_reg.drv_s[1];
	assign flags_nx[`MES_E_TEMP] = (temp_raw > st_reg.tmax);
	// Our own drive takes two sync stages to leave the sensed line, so mask it that long
	assign flags_nx[`MES_E_EXT] = ~st_reg.cfg.extl_dis & st_reg.extl_s[1] & ~own_err
		& ~(|st_reg.own_d);
	// A new serial error wins over a clearing command in the same cycle
	assign flags_nx[`MES_E_SER] = serial_mode
		& ((|ser_kinds) | (st_reg.err[`MES_E_SER] & ~cmd_any));

	// Count events: rising edge of each error, plus each serial error kind
	assign cnt_ev = {ser_kinds, flags_nx & ~st_reg.err};
	assign cnt_clr = bus.wr && (bus.addr == `MES_OFF_CMD) && bus.wdata[`MES_CMD_CLRCNT];

	// Saturating counters; an event in the clearing cycle leaves a count of one
	generate
		for (genvar i = 0; i < NCNT; i++) begin : g_cnt
			always_comb begin
				if (cnt_clr) begin
					cnt_nx[i] = cnt_ev[i] ? CNT_W'(1) : '0;
				end else if (cnt_ev[i] && (st_reg.cnt[i] != {CNT_W{1'b1}})) begin
					cnt_nx[i] = st_reg.cnt[i] + CNT_W'(1);
				end else begin
					cnt_nx[i] = st_reg.cnt[i];
				end
			end
		end
	endgenerate

	assign cnt_idx = bus.addr[5:2];

	// Next-state of the whole block
	always_comb begin
		st_next = st_reg;

		// Pin synchronisers
		st_next.drv_s = {st_reg.drv_s[0], drv_fault_n};
		st_next.extl_s = {st_reg.extl_s[0], err_line_i};
		st_next.usb_s = {st_reg.usb_s[0], usb_present};
		// History of our own drive, matching the line synchroniser depth
		st_next.own_d = {st_reg.own_d[0], own_err};

		// Millisecond base
		st_next.ms_div = ms_tick ? 16'h0000 : st_reg.ms_div + 16'h0001;

		// Idle time since the last valid command
		if (cmd_any) begin
			st_next.idle_ms = 16'h0000;
		end else if (ms_tick && (st_reg.idle_ms != 16'hffff)) begin
			st_next.idle_ms = st_reg.idle_ms + 16'h0001;
		end

		// Error flags and the stop condition
		st_next.err = flags_nx;
		st_next.stop = |flags_nx;
		st_next.cnt = cnt_nx;

		// Drive speed: zero on any error, the request otherwise
		if (|flags_nx) begin
			st_next.speed = 13'h0000;
		end else begin
			st_next.speed = req_speed;
		end

		// Sticky serial kinds; a new event wins over a write-one clear
		if (bus.wr && (bus.addr == `MES_OFF_SKIND)) begin
			st_next.skind = st_reg.skind & ~bus.wdata[4:0];
		end
		st_next.skind = st_next.skind | ser_kinds;

		// USB indicator
		if (!st_reg.usb_s[1]) begin
			st_next.usb_ok = 1'b0;
			st_next.blink = 1'b0;
			st_next.led_ms = 10'h000;
			st_next.flick_ms = 8'h00;
		end else begin
			if (cmd.usb_drv_ok) begin
				st_next.usb_ok = 1'b1;
			end
			if (ms_tick) begin
				if (st_reg.led_ms == `MES_BLINK_MS - 10'h001) begin
					st_next.led_ms = 10'h000;
					st_next.blink = ~st_reg.blink;
				end else begin
					st_next.led_ms = st_reg.led_ms + 10'h001;
				end
				if (st_reg.flick_ms != 8'h00) begin
					st_next.flick_ms = st_reg.flick_ms - 8'h01;
				end
			end
			// Each transfer restarts the dark window
			if (cmd.usb_xfer) begin
				st_next.flick_ms = `MES_FLICK_MS;
			end
		end
		st_next.led = st_reg.usb_s[1]
			& (st_reg.usb_ok ? (st_reg.flick_ms == 8'h00) : st_reg.blink);

		// Register writes
		if (bus.wr) begin
			unique case (bus.addr)
				`MES_OFF_CFG: st_next.cfg = mes_cfg_t'(bus.wdata[10:0]);
				`MES_OFF_TMO: st_next.tmo = bus.wdata[15:0];
				`MES_OFF_VLOW: st_next.vlow = bus.wdata[15:0];
				`MES_OFF_VHIGH: st_next.vhigh = bus.wdata[15:0];
				`MES_OFF_TMAX: st_next.tmax = bus.wdata[11:0];
				default: ;
			endcase
		end

		// Register reads, answered in the next cycle
		st_next.rdata = 32'h0000_0000;
		if (bus.rd) begin
			unique case (bus.addr)
				`MES_OFF_CFG: st_next.rdata = {21'h000000, st_reg.cfg};
				`MES_OFF_TMO: st_next.rdata = {16'h0000, st_reg.tmo};
				`MES_OFF_VLOW: st_next.rdata = {16'h0000, st_reg.vlow};
				`MES_OFF_VHIGH: st_next.rdata = {16'h0000, st_reg.vhigh};
				`MES_OFF_TMAX: st_next.rdata = {20'h00000, st_reg.tmax};
				`MES_OFF_STAT: st_next.rdata = {21'h000000, st_reg.stop, st_reg.err};
				`MES_OFF_SKIND: st_next.rdata = {27'h0000000, st_reg.skind};
				default: begin
					if ((bus.addr[7:6] == 2'b01) && (cnt_idx < 4'(NCNT))) begin
						st_next.rdata = 32'(st_reg.cnt[cnt_idx]);
					end
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= ST_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from the state
	assign rdata = st_reg.rdata;
	assign err_flags = st_reg.err;
	assign motor_stop = st_reg.stop;
	assign motor_speed = st_reg.speed;
	assign usb_led = st_reg.led;
	// Line is driven high for own errors and released otherwise; an external pull-down holds it low
	assign err_line_o = 1'b1;
	assign err_line_oe_n = ~own_err;

endmodule : mes_supervisor
`default_nettype wire

// ===== verif/mes_supervisor_assertions.sv
// Port-level checks on the motor error supervisor
`timescale 1ns/100ps
`default_nettype none
module mes_sup_checker (
	input wire logic clk,
	input wire logic rst_n,
	input wire mes_pkg::mes_bus_req_t bus,
	input wire logic [31:0] rdata,
	input wire mes_pkg::mes_host_cmd_t cmd,
	input wire mes_pkg::mes_ser_ev_t ser_ev,
	input wire logic [15:0] vin_mv,
	input wire logic drv_fault_n,
	input wire logic err_line_oe_n,
	input wire logic [9:0] err_flags,
	input wire logic motor_stop,
	input wire logic [12:0] motor_speed
);
	import mes_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Fault pin must outlast the two-flop sync before the flag may be demanded
	sequence s_fault_held;
		!drv_fault_n [*4];
	endsequence
	sequence s_any_cmd;
		cmd.ser_valid || cmd.ser_resume || cmd.usb_set_speed || cmd.usb_exit_ss;
	endsequence
	AST_STOP_IS_OR: assert property (motor_stop == (|err_flags))
		else $error("stop differs from flag OR");
	AST_SPEED_ZERO: assert property (motor_stop |-> motor_speed == 13'h0)
		else $error("speed not zero while stopped");
	AST_LINE_IDLE: assert property (!motor_stop |-> err_line_oe_n)
		else $error("error line driven with no error");
	AST_DRV_FAULT: assert property (s_fault_held |-> err_flags[6])
		else $error("driver fault not flagged");
	AST_VIN_ZERO: assert property ((vin_mv == 16'h0) [*2] |-> err_flags[4])
		else $error("absent supply not flagged");
	AST_SER_CAUSE: assert property ($rose(err_flags[9]) |-> $past(|ser_ev))
		else $error("serial flag without event");
	AST_SER_CLEAR: assert property (err_flags[9] && cmd.ser_valid && !(|ser_ev) |=> !err_flags[9])
		else $error("serial flag kept after command");
	AST_SS_CAUSE: assert property ($rose(err_flags[0]) |-> $past(|err_flags[9:1]))
		else $error("safe start without other error");
	AST_TMO_CLEAR: assert property (err_flags[2] ##0 s_any_cmd |-> ##[1:2] !err_flags[2])
		else $error("timeout kept after command");
	AST_RDATA_IDLE: assert property (!$past(bus.rd) |-> rdata == 32'h0)
		else $error("read data outside read slot");
endmodule : mes_sup_checker
bind mes_supervisor mes_sup_checker mes_sup_checker_inst (.clk(clk), .rst_n(rst_n), .bus(bus),
	.rdata(rdata), .cmd(cmd), .ser_ev(ser_ev), .vin_mv(vin_mv), .drv_fault_n(drv_fault_n),
	.err_line_oe_n(err_line_oe_n), .err_flags(err_flags), .motor_stop(motor_stop),
	.motor_speed(motor_speed));
`default_nettype wire

// ===== verif/mes_host_model.sv
// Host model: serial and USB commands as one-cycle pulses
`timescale 1ns/100ps
`default_nettype none
module mes_host_model (
	input wire logic clk,
	output var mes_pkg::mes_host_cmd_t cmd
);
	import mes_pkg::*;
	initial cmd = '0;
	// Bit k: 5 valid, 4 resume, 3 set speed, 2 exit safe start, 1 driver ok, 0 transfer
	// A gap lets the host be prompt or slow before the next command
	task automatic send(input int k, input int gap);
		cmd <= mes_host_cmd_t'(6'h01 << k);
		@(posedge clk);
		cmd <= '0;
		repeat (gap + 1) @(posedge clk);
	endtask : send
endmodule : mes_host_model
`default_nettype wire

// ===== verif/mes_supervisor_tb.sv
// Self-checking bench for the motor error supervisor
`timescale 1ns/100ps
`default_nettype none
module mes_supervisor_tb;
	import mes_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	mes_bus_req_t bus = '0;
	mes_ser_ev_t ser_ev = '0;
	mes_chan_t chan = '0;
	logic [12:0] req_speed = 13'h0;
	logic [15:0] vin_mv = 16'h2ee0;
	logic [11:0] temp_raw = 12'h100;
	logic drv_fault_n = 1'b1;
	logic usb_present = 1'b0;
	logic ext_drv = 1'b0;
	mes_host_cmd_t cmd;
	logic [31:0] rdata;
	logic err_line_o, err_line_oe_n, motor_stop, usb_led;
	logic [9:0] err_flags;
	logic [12:0] motor_speed;
	int n_fail = 0;
	int num_checks = 0;
	int cyc = 0;
	// Shared line: pulled low, high if either party drives it
	wire logic err_line = ext_drv | (!err_line_oe_n & err_line_o);

	mes_supervisor #(.MS_CYCLES(4)) mes_supervisor_inst (.clk(clk), .rst_n(rst_n), .bus(bus),
		.rdata(rdata), .cmd(cmd), .ser_ev(ser_ev), .chan(chan), .req_speed(req_speed),
		.vin_mv(vin_mv), .temp_raw(temp_raw), .drv_fault_n(drv_fault_n),
		.usb_present(usb_present), .err_line_i(err_line), .err_line_o(err_line_o),
		.err_line_oe_n(err_line_oe_n), .err_flags(err_flags), .motor_stop(motor_stop),
		.motor_speed(motor_speed), .usb_led(usb_led));
	mes_host_model mes_host_model_inst (.clk(clk), .cmd(cmd));

	always #25 clk = ~clk;
	// Run is some 640 cycles; the ceiling leaves wide margin
	always @(posedge clk) begin
		cyc++;
		if (cyc == 8000) begin
			n_fail++;
			conclude();
		end
	end

	function automatic logic [9:0] fl(input int b);
		return 10'h1 << b;
	endfunction : fl
	function automatic logic [31:0] rst_val(input int i);
		case (i)
			2: return 32'h157c;
			3: return 32'h7530;
			4: return 32'ha0a;
			default: return 32'h0;
		endcase
	endfunction : rst_val
	task automatic chk_r(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_r
	// Wait out sync and safe start lag, then compare flags and forced speed
	task automatic chk_f(input logic [9:0] exp);
		repeat (10) @(posedge clk);
		#1;
		num_checks++;
		if (err_flags !== exp || (exp != 10'h0 && motor_speed !== 13'h0)) begin
			n_fail++;
			$display("mismatch at %0t: flags %h expected %h", $time, err_flags, exp);
		end
	endtask : chk_f
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		bus <= '0;
		@(posedge clk);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		bus <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge clk);
		#1;
		chk_r(rdata, exp);
		bus <= '0;
		@(posedge clk);
	endtask : rd
	task automatic ser_pulse(input mes_ser_ev_t v);
		ser_ev <= v;
		@(posedge clk);
		ser_ev <= '0;
		@(posedge clk);
	endtask : ser_pulse
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : conclude

	// Main sequence, one group per behaviour
	initial begin
		void'($urandom(86635));
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 6; i++) begin
			rd(8'(4 * i), rst_val(i));
		end
		chk_f(10'h0);
		for (int i = 0; i < 8; i++) begin
			vin_mv <= 16'($urandom_range(32'h7530, 32'h157c));
			req_speed <= 13'($urandom_range(6400) - 3200);
			chk_f(10'h0);
			chk_r(32'(motor_speed), 32'(req_speed));
		end
		$display("test reset done");
		vin_mv <= 16'h0;
		chk_f(fl(4) | fl(0));
		rd(8'h50, 32'h1);
		vin_mv <= 16'h2ee0;
		chk_f(fl(0));
		mes_host_model_inst.send(4, 2);
		chk_f(10'h0);
		wr(8'h1c, 32'h1);
		rd(8'h50, 32'h0);
		$display("test safe start done");
		// Safe start off so each fault shows alone
		wr(8'h00, 32'h1);
		vin_mv <= 16'h7531;
		chk_f(fl(5));
		chk_r(32'(err_line), 32'h1);
		vin_mv <= 16'h2ee0;
		temp_raw <= 12'ha0b;
		chk_f(fl(7));
		temp_raw <= 12'ha0a;
		drv_fault_n <= 1'b0;
		chk_f(fl(6));
		drv_fault_n <= 1'b1;
		ext_drv <= 1'b1;
		chk_f(fl(8));
		wr(8'h00, 32'h9);
		chk_f(10'h0);
		ext_drv <= 1'b0;
		$display("test faults done");
		wr(8'h00, 32'h11);
		for (int k = 0; k < 5; k++) begin
			ser_pulse(mes_ser_ev_t'(5'h01 << k));
			chk_f(fl(9));
			mes_host_model_inst.send(5 - k % 4, k);
			chk_f(10'h0);
		end
		rd(8'h18, 32'h1f);
		wr(8'h18, 32'h1f);
		rd(8'h18, 32'h0);
		wr(8'h00, 32'h1);
		ser_pulse(mes_ser_ev_t'(5'h10));
		chk_f(10'h0);
		$display("test serial done");
		wr(8'h04, 32'h2);
		repeat (8) @(posedge clk);
		chk_f(fl(2));
		mes_host_model_inst.send(3, 0);
		#1;
		chk_r(32'(err_flags), 32'h0);
		wr(8'h04, 32'h0);
		chk_f(10'h0);
		$display("test timeout done");
		wr(8'h00, 32'h21);
		chan <= '{2'b01, {13'h0, 13'h641}};
		chk_f(fl(3));
		chan.scaled[0] <= 13'h640;
		chk_f(10'h0);
		chan.valid <= 2'b00;
		chk_f(fl(1));
		wr(8'h00, 32'h41);
		chan <= '{2'b01, {13'h0, 13'h641}};
		req_speed <= 13'h64;
		chk_f(fl(3));
		req_speed <= 13'h1f9c;
		chk_f(10'h0);
		wr(8'h00, 32'h61);
		chk_f(fl(3));
		$display("test limits done");
		// Analog mode with channel 0 steering speed
		wr(8'h00, 32'h202);
		chan.scaled[0] <= 13'h3e8;
		vin_mv <= 16'h0;
		chk_f(fl(4) | fl(0));
		vin_mv <= 16'h2ee0;
		chk_f(fl(0));
		chan.scaled[0] <= 13'hff;
		chk_f(10'h0);
		$display("test analog done");
		chk_r(32'(usb_led), 32'h0);
		usb_present <= 1'b1;
		repeat (5) @(posedge clk);
		mes_host_model_inst.send(1, 140);
		#1;
		chk_r(32'(usb_led), 32'h1);
		mes_host_model_inst.send(0, 1);
		#1;
		chk_r(32'(usb_led), 32'h0);
		$display("test usb done");
		conclude();
	end
endmodule : mes_supervisor_tb
`default_nettype wire
